// ### rtl/rtcca_top.sv
// rtc calendar counters, alarm registers and apb slave
`timescale 1ns/1ps
`default_nettype none
module rtcca_top
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // rest of the rtc, same clock
   input wire logic run_enable,
   input wire logic day_carry,
   input wire logic [7:0] seconds_count,
   input wire logic [7:0] minutes_count,
   input wire logic [7:0] hours_count,
   // results
   output logic calendar_carry,
   output logic alarm_match,
   output logic alarm_event
);
   localparam int EB = rtcca_pkg::COMPARE_ENABLE_BIT;

   ////////////////////////////////////////////////////////////////////////////////
   // apb: one wait cycle so read data comes from a flop
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic access, wr_done;
   logic hit;
   logic [7:0] rd_val;

   logic [2:0] wk_r, wk_nxt;
   logic [7:0] date_r, date_nxt, month_r, month_nxt, year_r, year_nxt;
   logic [7:0] sec_al_r, sec_al_nxt, min_al_r, min_al_nxt, hour_al_r, hour_al_nxt;
   logic [7:0] wk_al_r, wk_al_nxt, date_al_r, date_al_nxt, mon_al_r, mon_al_nxt;
   logic [5:0] en_r, en_nxt;

   assign access = psel && penable;
   assign wr_done = access && pready_r && pwrite;

   always_comb
   begin
      hit = 1'b1;
      rd_val = 8'h00;
      case (paddr)
         rtcca_pkg::OFF_WEEKDAY_COUNT: rd_val = {5'h00, wk_r};
         rtcca_pkg::OFF_DATE_COUNT: rd_val = date_r & rtcca_pkg::MASK_DATE;
         rtcca_pkg::OFF_MONTH_COUNT: rd_val = month_r & rtcca_pkg::MASK_MONTH;
         rtcca_pkg::OFF_YEAR_COUNT: rd_val = year_r;
         rtcca_pkg::OFF_SECOND_ALARM: rd_val = {en_r[0], sec_al_r[6:0]};
         rtcca_pkg::OFF_MINUTE_ALARM: rd_val = {en_r[1], min_al_r[6:0]};
         rtcca_pkg::OFF_HOUR_ALARM: rd_val = {en_r[2], 1'b0, hour_al_r[5:0]};
         rtcca_pkg::OFF_WEEKDAY_ALARM: rd_val = {en_r[3], 4'h0, wk_al_r[2:0]};
         rtcca_pkg::OFF_DATE_ALARM: rd_val = {en_r[4], 1'b0, date_al_r[5:0]};
         rtcca_pkg::OFF_MONTH_ALARM: rd_val = {en_r[5], 2'b00, mon_al_r[4:0]};
         default: hit = 1'b0;
      endcase
      pready_nxt = access && !pready_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      if (access && !pready_r)
      begin
         prdata_nxt = pwrite ? prdata_r : {24'h000000, rd_val};
         pslverr_nxt = !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end
      else
      begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // calendar counters; a register write wins over a carry in the same cycle
   logic day_tick, month_tick, year_tick, leap, cal_wr;
   logic wr_wk, wr_date, wr_month, wr_year;

   assign wr_wk = wr_done && (paddr == rtcca_pkg::OFF_WEEKDAY_COUNT);
   assign wr_date = wr_done && (paddr == rtcca_pkg::OFF_DATE_COUNT);
   assign wr_month = wr_done && (paddr == rtcca_pkg::OFF_MONTH_COUNT);
   assign wr_year = wr_done && (paddr == rtcca_pkg::OFF_YEAR_COUNT);
   assign cal_wr = wr_wk || wr_date || wr_month || wr_year;
   // hours rollover 23 -> 00 arrives here as a one-cycle pulse
   assign day_tick = day_carry && run_enable;
   assign leap = rtcca_pkg::is_leap(year_r);
   assign month_tick = day_tick
      && (date_r == rtcca_pkg::last_day(month_r, leap));
   assign year_tick = month_tick && (month_r == rtcca_pkg::MONTH_LAST);

   always_comb
   begin
      wk_nxt = wk_r;
      date_nxt = date_r;
      month_nxt = month_r;
      year_nxt = year_r;
      if (wr_wk)
      begin
         wk_nxt = pwdata[2:0];
      end
      else if (day_tick)
      begin
         wk_nxt = (wk_r == rtcca_pkg::WEEKDAY_LAST) ? rtcca_pkg::WEEKDAY_FIRST
                : 3'(wk_r + 3'h1);
      end
      if (wr_date)
      begin
         date_nxt = pwdata[7:0] & rtcca_pkg::MASK_DATE;
      end
      else if (day_tick)
      begin
         date_nxt = month_tick ? rtcca_pkg::DATE_FIRST : rtcca_pkg::bcd_inc(date_r);
      end
      if (wr_month)
      begin
         month_nxt = pwdata[7:0] & rtcca_pkg::MASK_MONTH;
      end
      else if (month_tick)
      begin
         month_nxt = year_tick ? rtcca_pkg::MONTH_FIRST : rtcca_pkg::bcd_inc(month_r);
      end
      if (wr_year)
      begin
         year_nxt = pwdata[7:0];
      end
      else if (year_tick)
      begin
         year_nxt = (year_r == rtcca_pkg::YEAR_LAST) ? rtcca_pkg::YEAR_FIRST
                  : rtcca_pkg::bcd_inc(year_r);
      end
   end

   // no reset on purpose: the calendar must survive every reset
   always_ff @(posedge pclk)
   begin
      wk_r <= wk_nxt;
      date_r <= date_nxt;
      month_r <= month_nxt;
      year_r <= year_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // alarm registers: enables reset, values retained
   logic [5:0] wr_al;

   assign wr_al[0] = wr_done && (paddr == rtcca_pkg::OFF_SECOND_ALARM);
   assign wr_al[1] = wr_done && (paddr == rtcca_pkg::OFF_MINUTE_ALARM);
   assign wr_al[2] = wr_done && (paddr == rtcca_pkg::OFF_HOUR_ALARM);
   assign wr_al[3] = wr_done && (paddr == rtcca_pkg::OFF_WEEKDAY_ALARM);
   assign wr_al[4] = wr_done && (paddr == rtcca_pkg::OFF_DATE_ALARM);
   assign wr_al[5] = wr_done && (paddr == rtcca_pkg::OFF_MONTH_ALARM);

   always_comb
   begin
      en_nxt = en_r;
      for (int i = 0; i < 6; i++)
      begin
         if (wr_al[i])
         begin
            en_nxt[i] = pwdata[EB];
         end
      end
      sec_al_nxt = wr_al[0] ? (pwdata[7:0] & rtcca_pkg::MASK_SEC_ALARM) : sec_al_r;
      min_al_nxt = wr_al[1] ? (pwdata[7:0] & rtcca_pkg::MASK_MIN_ALARM) : min_al_r;
      hour_al_nxt = wr_al[2] ? (pwdata[7:0] & rtcca_pkg::MASK_HOUR_ALARM) : hour_al_r;
      wk_al_nxt = wr_al[3] ? (pwdata[7:0] & rtcca_pkg::MASK_WK_ALARM) : wk_al_r;
      date_al_nxt = wr_al[4] ? (pwdata[7:0] & rtcca_pkg::MASK_DATE_ALARM) : date_al_r;
      mon_al_nxt = wr_al[5] ? (pwdata[7:0] & rtcca_pkg::MASK_MON_ALARM) : mon_al_r;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_r <= {6{rtcca_pkg::COMPARE_ENABLE_RST}};
      end
      else
      begin
         en_r <= en_nxt;
      end
   end

   always_ff @(posedge pclk)
   begin
      sec_al_r <= sec_al_nxt;
      min_al_r <= min_al_nxt;
      hour_al_r <= hour_al_nxt;
      wk_al_r <= wk_al_nxt;
      date_al_r <= date_al_nxt;
      mon_al_r <= mon_al_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // combined match, registered; event on the first matching cycle
   logic match_c, any_en;
   logic hit_r, hit_nxt, evt_r, evt_nxt, carry_r, carry_nxt;

   rtcca_alarm_match u_match
   (
      .second_alarm({en_r[0], sec_al_r[6:0]}),
      .minute_alarm({en_r[1], min_al_r[6:0]}),
      .hour_alarm({en_r[2], hour_al_r[6:0]}),
      .weekday_alarm({en_r[3], wk_al_r[6:0]}),
      .date_alarm({en_r[4], date_al_r[6:0]}),
      .month_alarm({en_r[5], mon_al_r[6:0]}),
      .seconds_count(seconds_count),
      .minutes_count(minutes_count),
      .hours_count(hours_count),
      .weekday_count({5'h00, wk_r}),
      .date_count(date_r),
      .month_count(month_r),
      .any_enabled(any_en),
      .match(match_c)
   );

   always_comb
   begin
      hit_nxt = match_c;
      evt_nxt = match_c && !hit_r;
      // lets the control logic raise its carry flag for software retries
      carry_nxt = day_tick;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hit_r <= 1'b0;
         evt_r <= 1'b0;
         carry_r <= 1'b0;
      end
      else
      begin
         hit_r <= hit_nxt;
         evt_r <= evt_nxt;
         carry_r <= carry_nxt;
      end
   end

   assign alarm_match = hit_r;
   assign alarm_event = evt_r;
   assign calendar_carry = carry_r;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   chk_weekday_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (day_tick && !cal_wr && wk_r == 3'h6) |=> (wk_r == 3'h0))
      else $error("weekday did not wrap from 6 to 0");

   chk_date_year_end: assert property (@(posedge pclk) disable iff (!presetn)
      (day_tick && !cal_wr && date_r == 8'h31 && month_r == 8'h12)
      |=> (date_r == 8'h01 && month_r == 8'h01))
      else $error("year end did not reset date and month");

   chk_leap_feb: assert property (@(posedge pclk) disable iff (!presetn)
      (day_tick && !cal_wr && date_r == 8'h28 && month_r == 8'h02 && year_r == 8'h24)
      |=> (date_r == 8'h29 && month_r == 8'h02))
      else $error("leap february ended at 28");

   chk_month_step: assert property (@(posedge pclk) disable iff (!presetn)
      (day_tick && !cal_wr && date_r == 8'h30 && month_r == 8'h09)
      |=> (date_r == 8'h01 && month_r == 8'h10))
      else $error("september did not roll into october");

   chk_year_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (year_tick && !cal_wr && year_r == 8'h99) |=> (year_r == 8'h00))
      else $error("year did not wrap from 99 to 00");

   chk_alarm_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      !any_en |=> !alarm_match)
      else $error("alarm matched with no field enabled");

   chk_second_alarm: assert property (@(posedge pclk) disable iff (!presetn)
      (en_r[0] && {1'b0, sec_al_r[6:0]} != seconds_count) |=> !alarm_match)
      else $error("alarm matched on unequal seconds");

   chk_minute_alarm: assert property (@(posedge pclk) disable iff (!presetn)
      (en_r[1] && {1'b0, min_al_r[6:0]} != minutes_count) |=> !alarm_match)
      else $error("alarm matched on unequal minutes");

   chk_event_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      alarm_event |-> (alarm_match && !$past(alarm_match)) ##1 !alarm_event)
      else $error("alarm event not a single first-match pulse");

endmodule : rtcca_top
`default_nettype wire

// ### rtl/rtcca_pkg.sv
// constants and helpers for the rtc calendar and alarm compare block
package rtcca_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the apb
   localparam logic [7:0] OFF_WEEKDAY_COUNT = 8'h00;
   localparam logic [7:0] OFF_DATE_COUNT = 8'h04;
   localparam logic [7:0] OFF_MONTH_COUNT = 8'h08;
   localparam logic [7:0] OFF_YEAR_COUNT = 8'h0C;
   localparam logic [7:0] OFF_SECOND_ALARM = 8'h10;
   localparam logic [7:0] OFF_MINUTE_ALARM = 8'h14;
   localparam logic [7:0] OFF_HOUR_ALARM = 8'h18;
   localparam logic [7:0] OFF_WEEKDAY_ALARM = 8'h1C;
   localparam logic [7:0] OFF_DATE_ALARM = 8'h20;
   localparam logic [7:0] OFF_MONTH_ALARM = 8'h24;

   ////////////////////////////////////////////////////////////////////////////////
   // field layout: writable bits of each register, compare enable position
   localparam logic [7:0] MASK_WEEKDAY = 8'h07;
   localparam logic [7:0] MASK_DATE = 8'h3F;
   localparam logic [7:0] MASK_MONTH = 8'h1F;
   localparam logic [7:0] MASK_YEAR = 8'hFF;
   localparam logic [7:0] MASK_SEC_ALARM = 8'hFF;
   localparam logic [7:0] MASK_MIN_ALARM = 8'hFF;
   localparam logic [7:0] MASK_HOUR_ALARM = 8'hBF;
   localparam logic [7:0] MASK_WK_ALARM = 8'h87;
   localparam logic [7:0] MASK_DATE_ALARM = 8'hBF;
   localparam logic [7:0] MASK_MON_ALARM = 8'h9F;
   localparam int COMPARE_ENABLE_BIT = 7;
   localparam logic COMPARE_ENABLE_RST = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // counting limits, bcd
   localparam logic [2:0] WEEKDAY_LAST = 3'h6;
   localparam logic [2:0] WEEKDAY_FIRST = 3'h0;
   localparam logic [7:0] DATE_FIRST = 8'h01;
   localparam logic [7:0] MONTH_FIRST = 8'h01;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] MONTH_FEB = 8'h02;
   localparam logic [7:0] YEAR_FIRST = 8'h00;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] DAYS_LONG = 8'h31;
   localparam logic [7:0] DAYS_SHORT = 8'h30;
   localparam logic [7:0] DAYS_FEB = 8'h28;
   localparam logic [7:0] DAYS_FEB_LEAP = 8'h29;

   ////////////////////////////////////////////////////////////////////////////////
   // two-digit bcd increment, no wrap handling
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9)
      begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   // divisible by four: even tens with 0/4/8, odd tens with 2/6
   function automatic logic is_leap(input logic [7:0] y);
      if (!y[4])
      begin
         return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
   endfunction : is_leap

   function automatic logic [7:0] last_day(input logic [7:0] m, input logic leap);
      case (m)
         MONTH_FEB: return leap ? DAYS_FEB_LEAP : DAYS_FEB;
         8'h04, 8'h06, 8'h09, 8'h11: return DAYS_SHORT;
         default: return DAYS_LONG;
      endcase
   endfunction : last_day

   // an alarm field takes part only when its enable is set
   function automatic logic field_hit(input logic en, input logic [7:0] a, input logic [7:0] c);
      return !en || (a == c);
   endfunction : field_hit

endpackage : rtcca_pkg

// ### rtl/rtcca_alarm_match.sv
// combined compare of all six alarm registers against the counters
`timescale 1ns/1ps
`default_nettype none
module rtcca_alarm_match
(
   // alarm registers, enable in bit 7
   input wire logic [7:0] second_alarm,
   input wire logic [7:0] minute_alarm,
   input wire logic [7:0] hour_alarm,
   input wire logic [7:0] weekday_alarm,
   input wire logic [7:0] date_alarm,
   input wire logic [7:0] month_alarm,
   // counter values
   input wire logic [7:0] seconds_count,
   input wire logic [7:0] minutes_count,
   input wire logic [7:0] hours_count,
   input wire logic [7:0] weekday_count,
   input wire logic [7:0] date_count,
   input wire logic [7:0] month_count,
   // result
   output logic any_enabled,
   output logic match
);
   localparam int EB = rtcca_pkg::COMPARE_ENABLE_BIT;

   ////////////////////////////////////////////////////////////////////////////////
   // enable bit is masked off before the value compare
   always_comb
   begin
      any_enabled = second_alarm[EB] | minute_alarm[EB] | hour_alarm[EB]
                  | weekday_alarm[EB] | date_alarm[EB] | month_alarm[EB];
      match = any_enabled
         && rtcca_pkg::field_hit(second_alarm[EB], {1'b0, second_alarm[6:0]}, seconds_count)
         && rtcca_pkg::field_hit(minute_alarm[EB], {1'b0, minute_alarm[6:0]}, minutes_count)
         && rtcca_pkg::field_hit(hour_alarm[EB], {2'b00, hour_alarm[5:0]}, hours_count)
         && rtcca_pkg::field_hit(weekday_alarm[EB], {5'h00, weekday_alarm[2:0]}, weekday_count)
         && rtcca_pkg::field_hit(date_alarm[EB], {2'b00, date_alarm[5:0]}, date_count)
         && rtcca_pkg::field_hit(month_alarm[EB], {3'h0, month_alarm[4:0]}, month_count);
   end
endmodule : rtcca_alarm_match
`default_nettype wire

// ### verification/rtcca_top_bench.sv
// self-checking apb bench for the rtc calendar and alarm block
`timescale 1ns/1ps
`default_nettype none
module rtcca_top_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, seconds_count, minutes_count, hours_count;
   logic [31:0] pwdata, prdata, rdw;
   logic run_enable, day_carry, calendar_carry, alarm_match, alarm_event;
   logic [7:0] cal_addr [4];
   logic [31:0] dc_in [13];
   logic [31:0] dc_out [13];
   int n_errors = 0;
   int check_count = 0;

   rtcca_top u_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .run_enable(run_enable), .day_carry(day_carry), .seconds_count(seconds_count),
      .minutes_count(minutes_count), .hours_count(hours_count),
      .calendar_carry(calendar_carry), .alarm_match(alarm_match), .alarm_event(alarm_event)
   );

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            n_errors++;
            $display("[FAIL] %0t apb answer timed out", $time);
            summarize();
         end
         @(posedge pclk);
      end
      rdw = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
      check({31'h0, err}, 32'h0, "write error flag");
   endtask : wr

   task rdchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check(rdw, {24'h000000, exp}, "read data");
      check({31'h0, err}, 32'h0, "read error flag");
   endtask : rdchk

   // one edge later so the registered outputs have landed
   task outs(input logic m, input logic e, input logic c);
      @(posedge pclk);
      #1;
      check({29'h0, alarm_match, alarm_event, calendar_carry}, {29'h0, m, e, c}, "outputs");
   endtask : outs

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cal_addr = '{rtcca_pkg::OFF_WEEKDAY_COUNT, rtcca_pkg::OFF_DATE_COUNT,
                   rtcca_pkg::OFF_MONTH_COUNT, rtcca_pkg::OFF_YEAR_COUNT};
      // weekday, date, month, year before and after one day carry
      dc_in = '{32'h06280223, 32'h02280224, 32'h03290224, 32'h01280200, 32'h04300423,
                32'h05300123, 32'h00311299, 32'h01090523, 32'h02301119, 32'h03311219,
                32'h02280298, 32'h05300923, 32'h03310723};
      dc_out = '{32'h00010323, 32'h03290224, 32'h04010324, 32'h02290200, 32'h05010523,
                 32'h06310123, 32'h01010100, 32'h02100523, 32'h03011219, 32'h04010120,
                 32'h03010398, 32'h06011023, 32'h04010823};
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      run_enable = 1'b0;
      day_carry = 1'b0;
      seconds_count = 8'h04;
      minutes_count = 8'h17;
      hours_count = 8'h23;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      outs(1'b0, 1'b0, 1'b0);
      apb(1'b0, rtcca_pkg::OFF_SECOND_ALARM, 8'h00);
      check({31'h0, rdw[7]}, 32'h0, "second enable after reset");
      apb(1'b0, rtcca_pkg::OFF_MINUTE_ALARM, 8'h00);
      check({31'h0, rdw[7]}, 32'h0, "minute enable after reset");
      $display("test reset done");

      // unused upper bits and unmapped places
      for (int j = 0; j < 4; j++)
      begin
         wr(cal_addr[j], 8'hFF);
         rdchk(cal_addr[j], (j == 0) ? 8'h07 : (j == 1) ? 8'h3F
                          : (j == 2) ? 8'h1F : 8'hFF);
      end
      apb(1'b1, 8'h28, 8'h5A);
      check({31'h0, err}, 32'h1, "unmapped write error");
      apb(1'b0, 8'h28, 8'h00);
      check({rdw[30:0], err}, 32'h1, "unmapped read");
      $display("test fields done");

      // day carries across month, leap and year boundaries
      for (int i = 0; i < 13; i++)
      begin
         for (int j = 0; j < 4; j++)
            wr(cal_addr[j], dc_in[i][31-8*j -: 8]);
         @(posedge pclk);
         run_enable <= 1'b1;
         day_carry <= 1'b1;
         @(posedge pclk);
         day_carry <= 1'b0;
         run_enable <= 1'b0;
         #1;
         check({31'h0, calendar_carry}, 32'h1, "carry pulse");
         outs(1'b0, 1'b0, 1'b0);
         for (int j = 0; j < 4; j++)
            rdchk(cal_addr[j], dc_out[i][31-8*j -: 8]);
      end
      @(posedge pclk);
      day_carry <= 1'b1;
      @(posedge pclk);
      day_carry <= 1'b0;
      outs(1'b0, 1'b0, 1'b0);
      rdchk(rtcca_pkg::OFF_DATE_COUNT, 8'h01);
      $display("test calendar done");

      // alarm compare with per-field enables
      wr(rtcca_pkg::OFF_SECOND_ALARM, 8'h85);
      wr(rtcca_pkg::OFF_MINUTE_ALARM, 8'h12);
      outs(1'b0, 1'b0, 1'b0);
      @(posedge pclk);
      seconds_count <= 8'h05;
      outs(1'b1, 1'b1, 1'b0);
      outs(1'b1, 1'b0, 1'b0);
      wr(rtcca_pkg::OFF_MINUTE_ALARM, 8'h92);
      outs(1'b0, 1'b0, 1'b0);
      @(posedge pclk);
      minutes_count <= 8'h12;
      outs(1'b1, 1'b1, 1'b0);
      wr(rtcca_pkg::OFF_HOUR_ALARM, 8'hA2);
      outs(1'b0, 1'b0, 1'b0);
      @(posedge pclk);
      hours_count <= 8'h22;
      outs(1'b1, 1'b1, 1'b0);
      wr(rtcca_pkg::OFF_HOUR_ALARM, 8'h22);
      wr(rtcca_pkg::OFF_SECOND_ALARM, 8'h05);
      wr(rtcca_pkg::OFF_MINUTE_ALARM, 8'h12);
      outs(1'b0, 1'b0, 1'b0);
      wr(rtcca_pkg::OFF_SECOND_ALARM, 8'h85);
      outs(1'b1, 1'b1, 1'b0);
      // calendar now stands at weekday 4, date 01, month 08
      wr(rtcca_pkg::OFF_DATE_ALARM, 8'h82);
      outs(1'b0, 1'b0, 1'b0);
      wr(rtcca_pkg::OFF_DATE_ALARM, 8'h81);
      outs(1'b1, 1'b1, 1'b0);
      wr(rtcca_pkg::OFF_WEEKDAY_ALARM, 8'h84);
      outs(1'b1, 1'b0, 1'b0);
      wr(rtcca_pkg::OFF_MONTH_ALARM, 8'h88);
      outs(1'b1, 1'b0, 1'b0);
      rdchk(rtcca_pkg::OFF_MONTH_ALARM, 8'h88);
      $display("test alarm done");

      // second reset: enables drop, values and calendar kept
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      outs(1'b0, 1'b0, 1'b0);
      rdchk(rtcca_pkg::OFF_SECOND_ALARM, 8'h05);
      rdchk(rtcca_pkg::OFF_MINUTE_ALARM, 8'h12);
      rdchk(rtcca_pkg::OFF_DATE_COUNT, 8'h01);
      rdchk(rtcca_pkg::OFF_YEAR_COUNT, 8'h23);
      $display("test second reset done");
      summarize();
   end
endmodule : rtcca_top_bench
`default_nettype wire
